//--- logic/watchdog_pkg.sv
// Constants, register map and types shared by the watchdog design files.
// Assumes a 25 MHz core clock and 32-bit APB registers on aligned words.
package watchdog_pkg;
	// Clock and oscillator timing.
	localparam int CLK_PERIOD_NS = 40;
	localparam int RC_PERIOD_NS = 65000;
	localparam int RC_PERIOD_CYCLES = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [10:0] RC_TICK_LAST = 11'(RC_PERIOD_CYCLES - 1);
	localparam int INSTR_CLOCK_DIV = 4;
	localparam logic [1:0] INSTR_TICK_LAST = 2'(INSTR_CLOCK_DIV - 1);

	// Divider chain.
	localparam int FIXED_STAGES = 8;
	localparam int PRESCALE_STAGES = 7;
	localparam logic [FIXED_STAGES-1:0] FIXED_LAST = 8'hff;

	// Register indices and byte addresses.
	localparam logic [7:0] CONFIG_INDEX = 8'h09;
	localparam logic [7:0] CONFIG_ADDR = {CONFIG_INDEX[5:0], 2'h0};
	localparam logic [7:0] FLAGS_ADDR = 8'h40;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h44;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h48;

	// Configuration register layout.
	localparam logic [7:0] CONFIG_RESET = 8'h07;
	localparam int RATIO_LSB = 0;
	localparam int RATIO_MSB = 2;
	localparam int UNUSED_BIT = 3;
	localparam int TEST_LSB = 4;
	localparam int TEST_MSB = 7;
	localparam logic [3:0] TEST_DAC_WRITE = 4'h5;

	// Flag register layout.
	localparam int FLAG_TIMEOUT_BIT = 0;
	localparam int FLAG_POWERDOWN_BIT = 1;

	// Interrupt status and mask layout.
	localparam int IRQ_WIDTH = 2;
	localparam int IRQ_CHIP_RESET_BIT = 0;
	localparam int IRQ_WARM_RESET_BIT = 1;
	localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

	typedef enum {
		KICK_IDLE,
		KICK_FIRST_SEEN,
		KICK_SECOND_SEEN
	} kick_state_type;
endpackage : watchdog_pkg

//--- logic/watchdog_divider.sv
// Fixed divide-by-256 stage followed by the programmable prescaler.
// Assumes tick is a one-cycle pulse per watchdog source clock period.
`timescale 1ns/100ps
module watchdog_divider (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic tick,
	input wire logic [2:0] ratio,
	output logic overflow
);
	logic [watchdog_pkg::FIXED_STAGES-1:0] stage;
	logic [watchdog_pkg::PRESCALE_STAGES-1:0] pre;
	logic [watchdog_pkg::PRESCALE_STAGES-1:0] mask;
	logic preFull;
	logic stageFull;

	// Only the low ratio bits of the prescaler take part in the count.
	for (genvar i = 0; i < watchdog_pkg::PRESCALE_STAGES; i++) begin : g_mask
		assign mask[i] = (ratio > 3'(i)); // R4
	end

	assign preFull = &(pre | ~mask);
	assign stageFull = (stage == watchdog_pkg::FIXED_LAST);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= '0;
			pre <= '0;
		end else if (clear) begin
			stage <= '0; // R19
			pre <= '0; // R18
		end else if (tick) begin
			stage <= stage + 8'h01; // R3
			if (stageFull) begin
				if (preFull) begin
					pre <= '0;
				end else begin
					pre <= pre + 7'h01; // R4
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			overflow <= 1'b0;
		end else begin
			overflow <= !clear && tick && stageFull && preFull; // R19
		end
	end
endmodule : watchdog_divider

//--- logic/watchdog_timer_with_prescaler.sv
// Watchdog timer with clock source choice, fixed divider, prescaler and APB registers.
// Assumes core strobes arrive on mclk and configuration options are static levels.
//
// Summary of operation
// R1: Watchdog counts the RC oscillator or the core clock divided by four.
// R2: With the watchdog disabled, every watchdog operation including clears does nothing. Here a halt still clears the timeout flag.
// R3: The selected clock first passes a fixed eight-stage divide-by-256 divider.
// R4: Ratio field bits 2 to 0 set a prescale of two to that power.
// R5: Configuration bit 3 is unused and always reads zero.
// R6: Upper nibble is a test field; value 0101 selects DAC write mode.
// R7: On the instruction clock the watchdog stops counting during halt.
// R8: The RC oscillator runs through power-down unless an option turns it off.
// R9: Overflow in normal operation gives a chip reset and sets the timeout flag.
// R10: Overflow during halt gives a warm reset of program counter and stack only.
// R11: Count clears on external reset, a valid software clear, or halt.
// R12: An option picks single or paired clear instructions, never both.
// R13: In single mode each single clear instruction clears the counter at once.
// R14: In paired mode both first and second clears must occur before clearing.
// R15: The RC oscillator model has a typical period of 65 microseconds.
// R16: Halt stops the system oscillator; core strobes are ignored until wake-up.
// R17: Timeout flag clears on power-up, clear instruction or halt; sets on timeout.
// R18: Halt clears the counter and prescaler and counting restarts.
// R19: Overflow after 256 times the ratio source periods; chain restarts on clear.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
module watchdog_timer_with_prescaler (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic optWdtEnable,
	input wire logic optClockRc,
	input wire logic optPairedClear,
	input wire logic optRcOffInHalt,
	input wire logic watchdogKickSingle,
	input wire logic watchdogKickFirst,
	input wire logic watchdogKickSecond,
	input wire logic haltExec,
	input wire logic haltActive,
	output logic chipReset,
	output logic warmReset,
	output logic timeoutFlag,
	output logic powerdownFlag,
	output logic dacWriteMode,
	output logic irq
);
	logic accessStart;
	logic accessDone;
	logic wrDone;
	logic rdDone;
	logic selConfig;
	logic selFlags;
	logic selStatus;
	logic selMask;
	logic mapped;
	logic [31:0] readValue;

	logic [1:0] instrCount;
	logic instrTick;
	logic [10:0] rcCount;
	logic rcRunning;
	logic rcTick;
	logic sourceTick;

	watchdog_pkg::kick_state_type kickState;
	watchdog_pkg::kick_state_type next_kickState;
	logic kickValid;
	logic kickInputs;
	logic divClear;
	logic overflow;
	logic normalOverflow;
	logic haltOverflow;

	logic [7:0] wdConfig;
	logic [7:0] next_wdConfig;
	logic [watchdog_pkg::IRQ_WIDTH-1:0] irqStatus;
	logic [watchdog_pkg::IRQ_WIDTH-1:0] next_irqStatus;
	logic [watchdog_pkg::IRQ_WIDTH-1:0] irqMask;
	logic [watchdog_pkg::IRQ_WIDTH-1:0] irqEvents;
	logic [watchdog_pkg::IRQ_WIDTH-1:0] irqCleared;

	// APB access: pready rises one cycle into the access phase.
	assign accessStart = psel && penable && !pready;
	assign accessDone = psel && penable && pready;
	assign wrDone = accessDone && pwrite;
	assign rdDone = accessDone && !pwrite;
	// Decode on the full byte address; unmapped words answer with an error and read zero.
	assign selConfig = (paddr == watchdog_pkg::CONFIG_ADDR);
	assign selFlags = (paddr == watchdog_pkg::FLAGS_ADDR);
	assign selStatus = (paddr == watchdog_pkg::IRQ_STATUS_ADDR);
	assign selMask = (paddr == watchdog_pkg::IRQ_MASK_ADDR);
	assign mapped = selConfig || selFlags || selStatus || selMask;

	always_comb begin
		readValue = 32'h0000_0000;
		if (selConfig) begin
			readValue[7:0] = wdConfig;
		end else if (selFlags) begin
			readValue[watchdog_pkg::FLAG_TIMEOUT_BIT] = timeoutFlag;
			readValue[watchdog_pkg::FLAG_POWERDOWN_BIT] = powerdownFlag;
		end else if (selStatus) begin
			readValue[watchdog_pkg::IRQ_WIDTH-1:0] = irqStatus;
		end else if (selMask) begin
			readValue[watchdog_pkg::IRQ_WIDTH-1:0] = irqMask;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= accessStart;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= accessStart && !mapped;
		end
	end

	// Read data hold until the next access, so the status clear can use what was returned.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (accessStart) begin
			prdata <= pwrite ? 32'h0000_0000 : readValue;
		end
	end

	// Instruction clock: the core clock divided by four, frozen while halted
	// because the system oscillator is then stopped.
	assign instrTick = (instrCount == watchdog_pkg::INSTR_TICK_LAST) && !haltActive; // R7

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			instrCount <= 2'h0;
		end else if (!haltActive) begin
			instrCount <= instrCount + 2'h1; // R1
		end
	end

	// The RC oscillator is modelled as a tick every typical period. Its real
	// period drifts, so software must not rely on exact time-outs.
	assign rcRunning = !(haltActive && optRcOffInHalt); // R8
	assign rcTick = rcRunning && (rcCount == watchdog_pkg::RC_TICK_LAST); // R15

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rcCount <= 11'h000;
		end else if (rcRunning) begin
			if (rcCount == watchdog_pkg::RC_TICK_LAST) begin
				rcCount <= 11'h000; // R15
			end else begin
				rcCount <= rcCount + 11'h001;
			end
		end
	end

	// A disabled watchdog gets no ticks, so its chain cannot advance even for one cycle.
	assign sourceTick = optWdtEnable && (optClockRc ? rcTick : instrTick); // R1

	// Software clears. Core strobes are ignored while halted.
	assign kickInputs = optWdtEnable && !haltActive; // R2 R16

	// In paired mode the halves may come in either order or together; a repeated half is ignored.
	always_comb begin
		next_kickState = kickState;
		kickValid = 1'b0;
		if (!kickInputs) begin
			kickValid = 1'b0;
		end else if (!optPairedClear) begin
			next_kickState = watchdog_pkg::KICK_IDLE;
			kickValid = watchdogKickSingle; // R12 R13
		end else begin
			case (kickState) // R12 R14
				watchdog_pkg::KICK_IDLE: begin
					if (watchdogKickFirst && watchdogKickSecond) begin
						kickValid = 1'b1;
					end else if (watchdogKickFirst) begin
						next_kickState = watchdog_pkg::KICK_FIRST_SEEN;
					end else if (watchdogKickSecond) begin
						next_kickState = watchdog_pkg::KICK_SECOND_SEEN;
					end
				end
				watchdog_pkg::KICK_FIRST_SEEN: begin
					if (watchdogKickSecond) begin
						kickValid = 1'b1;
						next_kickState = watchdog_pkg::KICK_IDLE;
					end
				end
				watchdog_pkg::KICK_SECOND_SEEN: begin
					if (watchdogKickFirst) begin
						kickValid = 1'b1;
						next_kickState = watchdog_pkg::KICK_IDLE;
					end
				end
				default: begin
					next_kickState = watchdog_pkg::KICK_IDLE;
				end
			endcase
		end
		if (haltExec || overflow) begin
			next_kickState = watchdog_pkg::KICK_IDLE;
		end
	end

	// The pairing state is kept while kicks are ignored; a halt or an overflow returns it to idle.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			kickState <= watchdog_pkg::KICK_IDLE;
		end else begin
			kickState <= next_kickState;
		end
	end

	// A disabled watchdog holds its chain cleared so that it never overflows.
	assign divClear = !optWdtEnable || kickValid || haltExec; // R2 R11 R18

	// The ratio comes straight from the register, so a new ratio applies to the count in progress.
	watchdog_divider u_divider (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(divClear),
		.tick(sourceTick),
		.ratio(wdConfig[watchdog_pkg::RATIO_MSB:watchdog_pkg::RATIO_LSB]),
		.overflow(overflow)
	);

	// Only an overflow outside halt is a full chip reset; in halt it wakes the core with a warm reset.
	assign normalOverflow = overflow && !haltActive;
	assign haltOverflow = overflow && haltActive;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chipReset <= 1'b0;
		end else begin
			chipReset <= normalOverflow; // R9
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			warmReset <= 1'b0;
		end else begin
			warmReset <= haltOverflow; // R10
		end
	end

	// The timeout flag is set in both modes so software can tell the cause.
	// A set in the same cycle as a clear wins.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timeoutFlag <= 1'b0;
		end else if (overflow) begin
			timeoutFlag <= 1'b1; // R9 R17
		end else if (kickValid || haltExec) begin
			timeoutFlag <= 1'b0; // R17
		end
	end

	// The power-down flag records a halt while the watchdog is enabled, so software can tell a wake-up from a cold start.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			powerdownFlag <= 1'b0;
		end else if (haltExec && optWdtEnable) begin
			powerdownFlag <= 1'b1;
		end else if (kickValid) begin
			powerdownFlag <= 1'b0;
		end
	end

	// Configuration register. A warm reset leaves it as it is.
	always_comb begin
		next_wdConfig = wdConfig;
		if (normalOverflow) begin
			next_wdConfig = watchdog_pkg::CONFIG_RESET; // R9
		end else if (wrDone && selConfig) begin
			next_wdConfig = pwdata[7:0];
		end
		next_wdConfig[watchdog_pkg::UNUSED_BIT] = 1'b0; // R5
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wdConfig <= watchdog_pkg::CONFIG_RESET;
		end else begin
			wdConfig <= next_wdConfig;
		end
	end

	// The test nibble is decoded from the next value, so the mode flag moves with the register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dacWriteMode <= 1'b0;
		end else begin
			dacWriteMode <= (next_wdConfig[watchdog_pkg::TEST_MSB:watchdog_pkg::TEST_LSB]
				== watchdog_pkg::TEST_DAC_WRITE); // R6
		end
	end

	// Interrupt status clears on read, but only the bits that the read returned,
	// so an event arriving between capture and completion is not lost.
	assign irqEvents[watchdog_pkg::IRQ_CHIP_RESET_BIT] = normalOverflow;
	assign irqEvents[watchdog_pkg::IRQ_WARM_RESET_BIT] = haltOverflow;
	assign irqCleared = (rdDone && selStatus) ? prdata[watchdog_pkg::IRQ_WIDTH-1:0] : '0;

	for (genvar i = 0; i < watchdog_pkg::IRQ_WIDTH; i++) begin : g_irq
		assign next_irqStatus[i] = irqEvents[i] || (irqStatus[i] && !irqCleared[i]);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= next_irqStatus;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqMask <= watchdog_pkg::IRQ_MASK_RESET;
		end else if (wrDone && selMask) begin
			irqMask <= pwdata[watchdog_pkg::IRQ_WIDTH-1:0];
		end
	end

	// A mask write counts at once, so the line follows the new mask on the same edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irqStatus & ((wrDone && selMask) ? pwdata[watchdog_pkg::IRQ_WIDTH-1:0] : irqMask));
		end
	end
endmodule : watchdog_timer_with_prescaler

//--- bench/watchdog_checker_sva.sv
// Concurrent checks on the watchdog top-level ports.
// Assumes the bind below and a single mclk domain with rst_n active low.
`timescale 1ns/100ps
module watchdog_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic optWdtEnable,
	input wire logic optClockRc,
	input wire logic optPairedClear,
	input wire logic watchdogKickSingle,
	input wire logic haltExec,
	input wire logic haltActive,
	input wire logic chipReset,
	input wire logic warmReset,
	input wire logic timeoutFlag,
	input wire logic dacWriteMode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chip_normal_a: assert property (chipReset |-> !$past(haltActive)) else $error("chip reset in halt");
	chip_flag_a: assert property (chipReset |-> timeoutFlag) else $error("timeout flag missing");
	warm_halt_a: assert property (warmReset |-> $past(haltActive)) else $error("warm reset outside halt");
	warm_source_a: assert property (warmReset |-> $past(optClockRc)) else $error("count ran in halt");
	off_quiet_a: assert property (!optWdtEnable && !$past(optWdtEnable) && !$past(optWdtEnable, 2)
		|-> !chipReset && !warmReset) else $error("disabled watchdog fired");
	kick_flag_a: assert property (watchdogKickSingle && optWdtEnable && !haltActive && !optPairedClear
		|=> !timeoutFlag || chipReset) else $error("kick left flag set");
	halt_flag_a: assert property (haltExec |=> !timeoutFlag || chipReset || warmReset)
		else $error("halt left flag set");
	bit3_zero_a: assert property (pready && !pwrite && paddr == watchdog_pkg::CONFIG_ADDR
		|-> prdata[31:8] == 24'h0 && !prdata[3]) else $error("config unused bits set");
	cover property (chipReset);
	cover property (dacWriteMode);
	cover property (haltExec && haltActive);
endmodule : watchdog_checker
bind watchdog_timer_with_prescaler watchdog_checker chk (.mclk, .rst_n, .pwrite, .paddr, .prdata, .pready,
	.optWdtEnable, .optClockRc, .optPairedClear, .watchdogKickSingle, .haltExec, .haltActive,
	.chipReset, .warmReset, .timeoutFlag, .dacWriteMode);

//--- bench/watchdog_timer_with_prescaler_test.sv
// Self-checking bench for the watchdog: registers, overflow timing, clears and halt.
// Assumes the checker is bound to the top module and a 40 ns mclk.
`timescale 1ns/100ps
module watchdog_timer_with_prescaler_test;
	localparam logic [7:0] CFG = watchdog_pkg::CONFIG_ADDR;
	localparam logic [7:0] FLG = watchdog_pkg::FLAGS_ADDR;
	localparam logic [7:0] STS = watchdog_pkg::IRQ_STATUS_ADDR;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic optWdtEnable, optClockRc, optPairedClear, optRcOffInHalt, haltExec, haltActive;
	logic watchdogKickSingle, watchdogKickFirst, watchdogKickSecond;
	logic chipReset, warmReset, timeoutFlag, powerdownFlag, dacWriteMode, irq;
	int err_count, cmp_count, n, v;
	int cfgQ[$];
	watchdog_timer_with_prescaler dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .optWdtEnable, .optClockRc, .optPairedClear, .optRcOffInHalt, .watchdogKickSingle,
		.watchdogKickFirst, .watchdogKickSecond, .haltExec, .haltActive, .chipReset, .warmReset,
		.timeoutFlag, .powerdownFlag, .dacWriteMode, .irq);
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	task summarize;
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Reference model: overflow comes 256 times the prescale ratio source ticks after a clear.
	function automatic int period(input int r);
		return 256 * (1 << r) * watchdog_pkg::INSTR_CLOCK_DIV;
	endfunction : period
	// The setup phase lasts one cycle; the access phase is held until pready is seen at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, q, x);
	endtask : rd
	task pulse(input int k);
		@(posedge mclk);
		case (k)
			0: watchdogKickSingle <= 1'b1;
			1: watchdogKickFirst <= 1'b1;
			2: watchdogKickSecond <= 1'b1;
			default: haltExec <= 1'b1;
		endcase
		@(posedge mclk);
		{watchdogKickSingle, watchdogKickFirst, watchdogKickSecond, haltExec} <= 4'h0;
	endtask : pulse
	task waitRst(input int lim);
		n = 0;
		while (chipReset !== 1'b1 && warmReset !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
	endtask : waitRst
	initial begin
		#(40 * 60000);
		err_count++;
		summarize();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, optClockRc, optPairedClear, optRcOffInHalt} = 0;
		{haltExec, haltActive, watchdogKickSingle, watchdogKickFirst, watchdogKickSecond} = 0;
		optWdtEnable = 1'b1;
		v = $urandom(26467);
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(CFG, watchdog_pkg::CONFIG_RESET, "config");
		rd(FLG, 32'h0, "flags");
		apb(1'b0, 8'h30, 32'h0);
		check("slverr", e, 1);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h55 : (i == 1) ? 32'hff : $urandom % 256;
			cfgQ.push_back(v & 32'hf7);
			apb(1'b1, CFG, v);
			rd(CFG, cfgQ.pop_front(), "config");
			check("dac", dacWriteMode, ((v >> 4) == 5));
		end
		// Each ratio is reloaded because a chip reset restores the default ratio.
		for (int r = 0; r < 5; r++) begin
			apb(1'b1, watchdog_pkg::IRQ_MASK_ADDR, (r != 1));
			apb(1'b1, CFG, r);
			pulse(0);
			waitRst(140000);
			check("period", n >= period(r) - 8 && n <= period(r) + 8, 1);
			rd(FLG, 32'h1, "timeout");
			check("timeout pin", timeoutFlag, 1);
			check("irq", irq, (r != 1));
			rd(STS, 32'h1, "status");
			rd(STS, 32'h0, "status");
			check("irq", irq, 0);
			pulse(0);
			rd(FLG, 32'h0, "timeout");
		end
		optPairedClear <= 1'b1;
		apb(1'b1, CFG, 32'h0);
		pulse(1);
		pulse(2);
		repeat (500) @(posedge mclk);
		pulse(0);
		pulse(1);
		waitRst(3000);
		check("paired", n >= period(0) - 512 && n <= period(0) - 496, 1);
		optPairedClear <= 1'b0;
		apb(1'b1, CFG, 32'h0);
		optWdtEnable <= 1'b0;
		pulse(0);
		waitRst(3000);
		check("disabled", n, 3000);
		optWdtEnable <= 1'b1;
		apb(1'b1, CFG, 32'h0);
		haltActive <= 1'b1;
		pulse(3);
		waitRst(3000);
		check("halted", n, 3000);
		rd(FLG, 32'h2, "flags");
		check("powerdown pin", powerdownFlag, 1);
		check("timeout pin", timeoutFlag, 0);
		haltActive <= 1'b0;
		pulse(0);
		rd(FLG, 32'h0, "flags");
		optClockRc <= 1'b1;
		apb(1'b1, CFG, 32'h0);
		pulse(0);
		waitRst(3000);
		check("rc source", n, 3000);
		summarize();
	end
endmodule : watchdog_timer_with_prescaler_test
